// >>> common/tpc_consts.svh
// constants for the transceiver power mode controller
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH
// ---------------------------------------------------------------
// apb register offsets (byte addresses)
// ---------------------------------------------------------------
`define TPC_OFS_CTRL 12'h000
`define TPC_OFS_STATUS 12'h004
`define TPC_OFS_RX_WORD 12'h008
`define TPC_OFS_TX_WORD 12'h00c
`define TPC_OFS_M1_WORD 12'h010
`define TPC_OFS_M2_WORD 12'h014
`define TPC_OFS_SETTLE 12'h018
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define TPC_CTRL_LOAD 0
`define TPC_CTRL_MODE 1
`define TPC_CTRL_DIR 2
`define TPC_CTRL_RUN 3
`define TPC_CTRL_SLEEP 4
`define TPC_CTRL_USER 5
// ---------------------------------------------------------------
// device serial word layout and suggested words
// ---------------------------------------------------------------
`define TPC_WORD_BITS 24
`define TPC_ADDR_BITS 4
`define TPC_ADDR_RX 4'h0
`define TPC_ADDR_TX 4'h1
`define TPC_ADDR_M1 4'h2
`define TPC_ADDR_M2 4'h3
`define TPC_UNUSED_MASK 24'h7d_ffff
`define TPC_TDMA_RX 24'h59_e200
`define TPC_TDMA_TX 24'h08_1ff1
`define TPC_TDMA_M1 24'h18_8262
`define TPC_TDMA_M2 24'h59_fff3
`define TPC_AMPS_RX 24'h5d_e200
`define TPC_AMPS_TX 24'h5d_fff1
`define TPC_AMPS_M1 24'h18_8262
`define TPC_AMPS_M2 24'h5d_fff3
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TPC_SCLK_DIV 8'h04
`define TPC_SETTLE_RESET 16'h00fa
`endif

// >>> common/tpc_pkg.sv
// types for the transceiver power mode controller
package tpc_pkg;
  typedef struct packed {
    logic serial_clock;
    logic serial_input_line;
    logic serial_word_latch;
    logic direction_select_pin;
    logic stage_one_power_pin;
    logic stage_two_power_pin;
  } tpc_pins_type;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } tpc_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tpc_apb_rsp_type;
  typedef enum logic [5:0] {
    TPC_IDLE = 6'b00_0001,
    TPC_LOAD = 6'b00_0010,
    TPC_WAIT = 6'b00_0100,
    TPC_STG1 = 6'b00_1000,
    TPC_STG2 = 6'b01_0000,
    TPC_SLEEP = 6'b10_0000
  } tpc_state_type;
endpackage

// >>> logic/tpc_serial_shifter.sv
// serial word shifter toward the device's three-wire bus
`timescale 1ns/1ps
`include "tpc_consts.svh"
module tpc_serial_shifter #(
  parameter int WORD_BITS = `TPC_WORD_BITS,
  parameter logic [7:0] DIV = `TPC_SCLK_DIV
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic start, // one-cycle request to send word
  input wire logic [WORD_BITS-1:0] word, // word to send
  output logic busy, // word in flight
  output logic done, // one-cycle pulse at end
  output logic sclk, // serial clock to device
  output logic sdata, // serial data to device
  output logic latch // word latch pulse
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic done;
    logic sclk;
    logic sdata;
    logic latch;
    logic [7:0] div;
    logic [5:0] bits;
    logic phase;
    logic [WORD_BITS-1:0] sreg;
  } tpc_shift_type;
  tpc_shift_type r;
  tpc_shift_type next_r;
  logic tick;
  assign busy = r.busy;
  assign done = r.done;
  assign sclk = r.sclk;
  assign sdata = r.sdata;
  assign latch = r.latch;
  assign tick = (r.div == 8'h00);
  // one enable per half bit; data moves on the low phase, msb first
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (r.busy) begin
      next_r.div = tick ? DIV - 8'h01 : r.div - 8'h01;
    end
    if (!r.busy && start) begin
      next_r.busy = 1'b1;
      next_r.sreg = word;
      next_r.sdata = word[WORD_BITS-1];
      next_r.bits = 6'(WORD_BITS);
      next_r.phase = 1'b0;
      next_r.div = DIV - 8'h01;
    end else if (r.busy && tick) begin
      if (r.latch) begin
        // latch pulse closes the word
        next_r.latch = 1'b0;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else if (r.bits == 6'h00) begin
        next_r.latch = 1'b1;
      end else if (!r.phase) begin
        next_r.sclk = 1'b1;
        next_r.phase = 1'b1;
      end else begin
        next_r.sclk = 1'b0;
        next_r.phase = 1'b0;
        next_r.bits = r.bits - 6'h01;
        next_r.sreg = {r.sreg[WORD_BITS-2:0], 1'b0};
        next_r.sdata = r.sreg[WORD_BITS-2];
      end
    end
  end
  // register the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// >>> logic/tpc_power_controller.sv
// apb-driven controller of transceiver power control words and pins
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "tpc_consts.svh"
module tpc_power_controller
  import tpc_pkg::*;
#(
  parameter logic [7:0] SCLK_DIV = `TPC_SCLK_DIV
) (
  input wire logic pclk, // apb clock, 25 mhz
  input wire logic presetn, // async reset, active low
  input wire tpc_pkg::tpc_apb_req_type apb_req, // apb request
  output tpc_pkg::tpc_apb_rsp_type apb_rsp, // apb response
  output tpc_pkg::tpc_pins_type pins // device pins
);
  import tpc_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    tpc_state_type st;
    logic [2:0] widx;
    logic sent;
    logic mode_amps;
    logic dir_tx;
    logic user;
    logic loaded;
    logic [23:0] rx_word;
    logic [23:0] tx_word;
    logic [23:0] m1_word;
    logic [23:0] m2_word;
    logic [15:0] settle;
    logic [15:0] cnt;
    logic load_err;
    tpc_apb_rsp_type rsp;
    logic dir_pin;
    logic en1;
    logic en2;
  } tpc_ctl_type;
  tpc_ctl_type r;
  tpc_ctl_type next_r;
  logic sh_start;
  logic [23:0] sh_word;
  logic sh_busy;
  logic sh_done;
  logic sh_sclk;
  logic sh_sdata;
  logic sh_latch;
  logic wr;
  logic rd;
  logic [23:0] pick;
  // ---------------------------------------------------------------
  // serial bus shifter
  // ---------------------------------------------------------------
  tpc_serial_shifter #(.WORD_BITS(`TPC_WORD_BITS), .DIV(SCLK_DIV)) u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .start(sh_start),
    .word(sh_word),
    .busy(sh_busy),
    .done(sh_done),
    .sclk(sh_sclk),
    .sdata(sh_sdata),
    .latch(sh_latch)
  );
  // pins: serial lines pass through shifter flops, others from r
  always_comb begin
    pins.serial_clock = sh_sclk;
    pins.serial_input_line = sh_sdata;
    pins.serial_word_latch = sh_latch;
    pins.direction_select_pin = r.dir_pin;
    pins.stage_one_power_pin = r.en1;
    pins.stage_two_power_pin = r.en2;
  end
  assign apb_rsp = r.rsp;
  // ---------------------------------------------------------------
  // word selection for the load sequence
  // ---------------------------------------------------------------
  // user words or suggested words per mode; unused bits forced off
  always_comb begin
    unique case (r.widx[1:0])
      2'd0: pick = r.user ? r.rx_word
        : (r.mode_amps ? `TPC_AMPS_RX : `TPC_TDMA_RX);
      2'd1: pick = r.user ? r.tx_word
        : (r.mode_amps ? `TPC_AMPS_TX : `TPC_TDMA_TX);
      2'd2: pick = r.user ? r.m1_word
        : (r.mode_amps ? `TPC_AMPS_M1 : `TPC_TDMA_M1);
      default: pick = r.user ? r.m2_word
        : (r.mode_amps ? `TPC_AMPS_M2 : `TPC_TDMA_M2);
    endcase
    // low nibble carries the register address 0..3
    sh_word = (pick & `TPC_UNUSED_MASK & 24'hff_fff0)
      | {22'h00_0000, r.widx[1:0]};
    sh_start = (r.st == TPC_LOAD) && !r.sent && !sh_busy;
  end
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd = apb_req.psel && !apb_req.pwrite;
  // ---------------------------------------------------------------
  // apb slave and sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rsp.pready = 1'b0;
    next_r.rsp.pslverr = 1'b0;
    // zero-wait answer: pready in the cycle after setup
    if (apb_req.psel && !apb_req.penable) begin
      next_r.rsp.pready = 1'b1;
      next_r.rsp.prdata = 32'h0000_0000;
      if (rd) begin
        unique case (apb_req.paddr)
          `TPC_OFS_CTRL: next_r.rsp.prdata = {26'h000_0000, r.user,
            2'b00, r.dir_tx, r.mode_amps, 1'b0};
          `TPC_OFS_STATUS: next_r.rsp.prdata = {22'h00_0000,
            r.load_err, r.loaded, sh_busy, r.en2, r.en1, r.dir_pin,
            4'(r.st == TPC_IDLE ? 4'h0 : r.st == TPC_LOAD ? 4'h1
            : r.st == TPC_WAIT ? 4'h2 : r.st == TPC_STG1 ? 4'h3
            : r.st == TPC_STG2 ? 4'h4 : 4'h5)};
          `TPC_OFS_RX_WORD: next_r.rsp.prdata = {8'h00, r.rx_word};
          `TPC_OFS_TX_WORD: next_r.rsp.prdata = {8'h00, r.tx_word};
          `TPC_OFS_M1_WORD: next_r.rsp.prdata = {8'h00, r.m1_word};
          `TPC_OFS_M2_WORD: next_r.rsp.prdata = {8'h00, r.m2_word};
          `TPC_OFS_SETTLE: next_r.rsp.prdata = {16'h0000, r.settle};
          default: next_r.rsp.pslverr = 1'b1;
        endcase
      end else begin
        unique case (apb_req.paddr)
          `TPC_OFS_CTRL, `TPC_OFS_STATUS, `TPC_OFS_RX_WORD,
          `TPC_OFS_TX_WORD, `TPC_OFS_M1_WORD, `TPC_OFS_M2_WORD,
          `TPC_OFS_SETTLE: next_r.rsp.pslverr = 1'b0;
          default: next_r.rsp.pslverr = 1'b1;
        endcase
      end
    end
    // write effects land on the access edge
    if (wr && r.rsp.pready) begin
      unique case (apb_req.paddr)
        `TPC_OFS_CTRL: begin
          next_r.mode_amps = apb_req.pwdata[`TPC_CTRL_MODE];
          next_r.dir_tx = apb_req.pwdata[`TPC_CTRL_DIR];
          next_r.user = apb_req.pwdata[`TPC_CTRL_USER];
          if (apb_req.pwdata[`TPC_CTRL_LOAD]) begin
            // reloading with pins high would break sleep ordering
            next_r.st = TPC_LOAD;
            next_r.widx = 3'd0;
            next_r.sent = 1'b0;
            next_r.loaded = 1'b0;
            next_r.en1 = 1'b0;
            next_r.en2 = 1'b0;
          end else if (apb_req.pwdata[`TPC_CTRL_SLEEP]) begin
            next_r.st = TPC_SLEEP;
          end else if (apb_req.pwdata[`TPC_CTRL_RUN]) begin
            if (r.loaded && r.st != TPC_LOAD) begin
              next_r.st = TPC_STG1;
              next_r.cnt = r.settle;
            end else begin
              next_r.load_err = 1'b1;
            end
          end
        end
        `TPC_OFS_STATUS: next_r.load_err = 1'b0;
        `TPC_OFS_RX_WORD: next_r.rx_word = apb_req.pwdata[23:0];
        `TPC_OFS_TX_WORD: next_r.tx_word = apb_req.pwdata[23:0];
        `TPC_OFS_M1_WORD: next_r.m1_word = apb_req.pwdata[23:0];
        `TPC_OFS_M2_WORD: next_r.m2_word = apb_req.pwdata[23:0];
        `TPC_OFS_SETTLE: next_r.settle = apb_req.pwdata[15:0];
        default: next_r.load_err = r.load_err;
      endcase
    end
    // sequencer
    unique case (r.st)
      TPC_IDLE: begin
      end
      TPC_LOAD: begin
        // both stage pins held low through the whole load
        next_r.en1 = 1'b0;
        next_r.en2 = 1'b0;
        if (sh_start) begin
          next_r.sent = 1'b1;
        end
        // a done left over from a cut word must not advance the index
        if (sh_done && r.sent) begin
          next_r.sent = 1'b0;
          if (r.widx == 3'd3) begin
            next_r.st = TPC_IDLE;
            next_r.loaded = 1'b1;
          end else begin
            next_r.widx = r.widx + 3'd1;
          end
        end
      end
      TPC_WAIT: begin
        next_r.st = TPC_IDLE;
      end
      TPC_STG1: begin
        // oscillators and plls settle before the signal path
        next_r.dir_pin = r.dir_tx;
        next_r.en1 = 1'b1;
        next_r.en2 = 1'b0;
        if (r.cnt == 16'h0000) begin
          next_r.st = TPC_STG2;
        end else begin
          next_r.cnt = r.cnt - 16'h0001;
        end
      end
      TPC_STG2: begin
        // single direction pin: tdma is rx-only or tx-only
        next_r.dir_pin = r.dir_tx;
        next_r.en1 = 1'b1;
        next_r.en2 = 1'b1;
      end
      TPC_SLEEP: begin
        next_r.en1 = 1'b0;
        next_r.en2 = 1'b0;
        next_r.st = TPC_IDLE;
      end
      default: next_r.st = TPC_IDLE;
    endcase
  end
  // register the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= TPC_IDLE;
      r.settle <= `TPC_SETTLE_RESET;
      r.rx_word <= `TPC_TDMA_RX;
      r.tx_word <= `TPC_TDMA_TX;
      r.m1_word <= `TPC_TDMA_M1;
      r.m2_word <= `TPC_TDMA_M2;
    end else begin
      r <= next_r;
    end
  end
endmodule

// >>> sim/tpc_power_controller_props.sv
// assertion checker for the power controller ports
`timescale 1ns/1ps
module tpc_power_controller_props
  import tpc_pkg::*;
#(
  parameter logic [7:0] SCLK_DIV = 8'h04
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire tpc_pkg::tpc_apb_req_type apb_req, // apb request
  input wire tpc_pkg::tpc_apb_rsp_type apb_rsp, // apb response
  input wire tpc_pkg::tpc_pins_type pins // device pins
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic [4:0] bit_cnt;
  logic [7:0] latch_cnt;
  logic sclk_q;
  // cleared by each latch, so a short or long word shows at the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= 5'h00;
      latch_cnt <= 8'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= pins.serial_clock;
      latch_cnt <= pins.serial_word_latch ? latch_cnt + 8'h01 : 8'h00;
      if (pins.serial_word_latch) begin
        bit_cnt <= 5'h00;
      end else if (pins.serial_clock && !sclk_q) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end
  // ---------------------------------------------------------------
  // apb handshake and serial link
  // ---------------------------------------------------------------
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable && apb_rsp.pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no ready in first access cycle");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (apb_rsp.pready |->
    apb_req.psel && apb_req.penable)
    else $error("ready outside access phase");
  a_err_unmapped: assert property (s_setup and apb_req.paddr > 12'h018
    |=> apb_rsp.pslverr)
    else $error("unmapped access without error");
  a_bit_count: assert property ($rose(pins.serial_word_latch) |->
    bit_cnt == 5'd24)
    else $error("serial word not 24 bits");
  a_latch_width: assert property ($fell(pins.serial_word_latch) |->
    latch_cnt == SCLK_DIV)
    else $error("latch width wrong");
  a_data_stable: assert property (
    $changed(pins.serial_input_line) |-> !pins.serial_clock)
    else $error("serial data moved while clock high");
  a_load_pins_low: assert property ((pins.serial_clock ||
    pins.serial_word_latch) |->
    !pins.stage_one_power_pin && !pins.stage_two_power_pin)
    else $error("stage pins high during word load");
  a_stage_order: assert property ($rose(pins.stage_two_power_pin) |->
    $past(pins.stage_one_power_pin))
    else $error("stage two raised without stage one");
endmodule

// >>> sim/tpc_device_model.sv
// behavioural model of the transceiver's power control registers
`timescale 1ns/1ps
module tpc_device_model
  import tpc_pkg::*;
(
  input wire tpc_pkg::tpc_pins_type pins, // serial bus and mode pins
  output logic [23:0] rx_word, // receive selection
  output logic [23:0] tx_word, // transmit selection
  output logic [23:0] m1_word, // stage one mask
  output logic [23:0] m2_word, // stage two mask
  output logic [23:0] power // powered sections
);
  logic [23:0] shift_reg;
  // data taken on the rising serial clock, msb first
  always @(posedge pins.serial_clock) begin
    shift_reg <= {shift_reg[22:0], pins.serial_input_line};
  end
  // other addresses belong to registers this model leaves out
  always @(posedge pins.serial_word_latch) begin
    case (shift_reg[3:0])
      4'h0: rx_word <= shift_reg;
      4'h1: tx_word <= shift_reg;
      4'h2: m1_word <= shift_reg;
      4'h3: m2_word <= shift_reg;
      default: ;
    endcase
  end
  // low nibble is the address, never a section
  assign power = (pins.direction_select_pin ? tx_word : rx_word) &
    ((pins.stage_one_power_pin ? m1_word : 24'h00_0000) |
    (pins.stage_two_power_pin ? m2_word : 24'h00_0000)) & 24'hff_fff0;
endmodule

// >>> sim/tpc_power_controller_tb.sv
// self-checking testbench for the power controller
`timescale 1ns/1ps
`include "tpc_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tpc_power_controller_tb;
  import tpc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  tpc_apb_req_type apb_req = '0;
  tpc_apb_rsp_type apb_rsp;
  tpc_pins_type pins;
  logic [23:0] dev [4];
  logic [23:0] power;
  logic [31:0] q;
  logic e;
  int n_errors = 0;
  int num_checks = 0;
  logic [23:0] sug [2][4] = '{'{`TPC_TDMA_RX, `TPC_TDMA_TX, `TPC_TDMA_M1,
    `TPC_TDMA_M2}, '{`TPC_AMPS_RX, `TPC_AMPS_TX, `TPC_AMPS_M1, `TPC_AMPS_M2}};
  logic [23:0] ones [4] = '{default: 24'hff_ffff};
  always #20 pclk = ~pclk;
  tpc_power_controller #(.SCLK_DIV(8'h01)) dut (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .pins(pins));
  tpc_device_model model (.pins(pins), .rx_word(dev[0]), .tx_word(dev[1]),
    .m1_word(dev[2]), .m2_word(dev[3]), .power(power));
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  // one idle edge before each setup, so psel is never set twice at once
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    apb_req.paddr <= a;
    apb_req.pwrite <= w;
    apb_req.pwdata <= d;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  // poll until the four words are out and the sequencer is idle
  task automatic wait_idle();
    do begin
      apb(1'b0, `TPC_OFS_STATUS, 32'h0);
    end while (q[8] !== 1'b1 || q[3:0] !== 4'h0);
  endtask
  task automatic check_words(input logic [23:0] w [4]);
    logic [23:0] exp_w;
    for (int i = 0; i < 4; i++) begin
      // unused bits dropped, address nibble replaces the low bits
      exp_w = (w[i] & `TPC_UNUSED_MASK & 24'hff_fff0) | 24'(i);
      `CHK(dev[i], exp_w)
    end
  endtask
  // settle is 8, so stage one lasts well past the first look
  task automatic run_stages(input logic [31:0] base, input logic d);
    logic [23:0] sel;
    sel = d ? dev[1] : dev[0];
    apb(1'b1, `TPC_OFS_CTRL, base | 32'h0000_0008 | {29'h0, d, 2'b00});
    repeat (3) @(negedge pclk);
    `CHK(pins.direction_select_pin, d)
    `CHK(power, sel & dev[2] & 24'hff_fff0)
    repeat (14) @(negedge pclk);
    `CHK(power, sel & dev[3] & 24'hff_fff0)
    apb(1'b1, `TPC_OFS_CTRL, base | 32'h0000_0010);
    repeat (3) @(negedge pclk);
    `CHK(power, 24'h00_0000)
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TPC_OFS_CTRL, 32'h0);
    `CHK(q, 32'h0000_0000)
    apb(1'b0, `TPC_OFS_SETTLE, 32'h0);
    `CHK(q, 32'h0000_00fa)
    // run before any load is refused and flagged
    apb(1'b1, `TPC_OFS_CTRL, 32'h0000_0008);
    apb(1'b0, `TPC_OFS_STATUS, 32'h0);
    `CHK({q[9], q[6:5]}, 3'b100)
    apb(1'b1, `TPC_OFS_STATUS, 32'h0);
    apb(1'b0, `TPC_OFS_STATUS, 32'h0);
    `CHK(q[9], 1'b0)
    apb(1'b1, 12'h01c, 32'h0000_0001);
    `CHK(e, 1'b1)
    apb(1'b0, 12'h3fc, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b1, `TPC_OFS_SETTLE, 32'h0000_0008);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `TPC_OFS_CTRL, {30'h0, m[0], 1'b1});
      wait_idle();
      check_words(sug[m]);
      apb(1'b0, `TPC_OFS_CTRL, 32'h0);
      `CHK(q, {30'h0, m[0], 1'b0})
      run_stages({30'h0, m[0], 1'b0}, m[0]);
    end
    // user words with every bit set, unused bits must go out as zero
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `TPC_OFS_RX_WORD + 12'(4 * i), 32'hffff_ffff);
      apb(1'b0, `TPC_OFS_RX_WORD + 12'(4 * i), 32'h0);
      `CHK(q, 32'h00ff_ffff)
    end
    apb(1'b1, `TPC_OFS_CTRL, 32'h0000_0021);
    wait_idle();
    check_words(ones);
    apb(1'b0, `TPC_OFS_CTRL, 32'h0);
    `CHK(q, 32'h0000_0020)
    run_stages(32'h0000_0020, 1'b1);
    complete_run();
  end
  // whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    complete_run();
  end
endmodule
bind tpc_power_controller tpc_power_controller_props #(.SCLK_DIV(SCLK_DIV))
  u_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pins(pins));
